// >>> hdl/dsr_pkg.sv
// Purpose: Shared constants for the descriptor shadow register bank
// Assumes: Avalon-MM word addressing, 32-bit data
// Notes:   Register indices are local choices; byte address is four times the index
package dsr_pkg;
   localparam int          ADDR_W        = 4;
   localparam int          DATA_W        = 32;
   localparam int          CNT_W         = 12;   // Buffer byte count field width
   localparam int          STAT_W        = 16;   // Upper half of descriptor word 1
   localparam int          STAT_LSB      = 16;   // Status field position inside word 1
   // Register indices
   localparam logic [3:0]  IDX_CUR_RX_CNT  = 4'h0;
   localparam logic [3:0]  IDX_CUR_RX_STAT = 4'h1;
   localparam logic [3:0]  IDX_CUR_TX_CNT  = 4'h2;
   localparam logic [3:0]  IDX_CUR_TX_STAT = 4'h3;
   localparam logic [3:0]  IDX_NXT_RX_CNT  = 4'h4;
   localparam logic [3:0]  IDX_NXT_RX_STAT = 4'h5;
   localparam logic [3:0]  IDX_CONTROL     = 4'h6;
   localparam logic [3:0]  IDX_STATUS      = 4'h7;
   // Control and status register bit positions
   localparam int          CTL_STOP_BIT    = 0;
   localparam int          CTL_SUSP_BIT    = 1;
   localparam int          STS_REFUSED_BIT = 0;
   localparam logic [31:0] UNMAPPED_VALUE  = 32'h0000_0000;
   localparam logic [31:0] ZERO_WORD       = 32'h0000_0000;
   localparam logic [11:0] CNT_RESET       = 12'h000;
   localparam logic [15:0] STAT_RESET      = 16'h0000;
endpackage

// >>> hdl/dsr_shadow_field.sv
// Purpose: One shadow field, loaded by the descriptor engine or by software
// Assumes: Caller decides when software may write
// Notes:   No reset on purpose: contents survive every controller reset
`timescale 1ns/1ps
`default_nettype none
module dsr_shadow_field #(
   parameter int W = 12
) (
   input  wire logic         clk,
   input  wire logic         hwLoad,
   input  wire logic [W-1:0] hwData,
   input  wire logic         swLoad,
   input  wire logic [W-1:0] swData,
   output var  logic [W-1:0] value
);
   // Engine update wins over software; software writes whenever the caller raises swLoad, halted engine or not
   always_ff @(posedge clk) begin
      if (hwLoad) begin
         value <= hwData;
      end else if (swLoad) begin
         value <= swData;
      end
   end
endmodule
`default_nettype wire

// >>> hdl/dsr_sync2.sv
// Purpose: Two-flop synchroniser for a level from another domain
// Assumes: Input is a slow level
// Notes:   First stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module dsr_sync2 (
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic async,
   output var  logic synced
);
   logic meta_r;
   // Two stages against metastability
   always_ff @(posedge clk) begin
      if (!resetn) begin
         meta_r <= 1'b0;
         synced <= 1'b0;
      end else begin
         meta_r <= async;
         synced <= meta_r;
      end
   end
endmodule
`default_nettype wire

// >>> hdl/dsr_descriptor_shadow_registers.sv
// Purpose: Software-visible shadow copies of current/next descriptor word 1 fields
// Assumes: Descriptor engine on the same clock; Avalon-MM slave with waitrequest
// Notes:   Shadow contents have no reset; stop/suspend gate all software access to the shadow fields
`timescale 1ns/1ps
`default_nettype none
module dsr_descriptor_shadow_registers (
   input  wire logic                           clk,
   input  wire logic                           resetn,
   // Avalon-MM slave
   input  wire logic [dsr_pkg::ADDR_W-1:0]     avsAddress,
   input  wire logic                           avsRead,
   input  wire logic                           avsWrite,
   input  wire logic [dsr_pkg::DATA_W-1:0]     avsWritedata,
   input  wire logic [3:0]                     avsByteenable,
   output var  logic [dsr_pkg::DATA_W-1:0]     avsReaddata,
   output logic                                avsWaitrequest,
   // Descriptor engine, same clock
   input  wire logic                           curRxLoad,
   input  wire logic [dsr_pkg::DATA_W-1:0]     rx_descriptor_word1_cur,
   input  wire logic                           curTxLoad,
   input  wire logic [dsr_pkg::DATA_W-1:0]     tx_descriptor_word1_cur,
   input  wire logic                           nxtRxLoad,
   input  wire logic [dsr_pkg::DATA_W-1:0]     rx_descriptor_word1_nxt,
   // Halt state from the controller's command logic (another domain)
   input  wire logic                           stopPin,
   input  wire logic                           suspendPin,
   // Field views and access state for the engine
   output logic [dsr_pkg::CNT_W-1:0]           cur_rx_count_field,
   output logic [dsr_pkg::STAT_W-1:0]          cur_rx_status_field,
   output logic [dsr_pkg::CNT_W-1:0]           cur_tx_count_field,
   output logic [dsr_pkg::STAT_W-1:0]          cur_tx_status_field,
   output logic [dsr_pkg::CNT_W-1:0]           nxt_rx_count_field,
   output logic [dsr_pkg::STAT_W-1:0]          nxt_rx_status_field,
   output logic                                accessOpen
);
   localparam int CW = dsr_pkg::CNT_W;
   localparam int SW = dsr_pkg::STAT_W;
   localparam int SL = dsr_pkg::STAT_LSB;

   logic                    stopSync;
   logic                    suspSync;
   logic                    stopSw_r;
   logic                    suspSw_r;
   logic                    refused_r;
   logic                    ack_r;
   logic                    req;
   logic                    wrOk;
   logic                    ctlWr;
   logic                    stsWr;
   logic [SW-1:0]           wrLow;
   logic [dsr_pkg::DATA_W-1:0] rdNxt;
   logic                    swCurRxCnt;
   logic                    swCurRxSt;
   logic                    swCurTxCnt;
   logic                    swCurTxSt;
   logic                    swNxtRxCnt;
   logic                    swNxtRxSt;

   // Halt inputs come from the command domain, so synchronise first
   dsr_sync2 uStopSync (
      .clk    (clk),
      .resetn (resetn),
      .async  (stopPin),
      .synced (stopSync)
   );
   dsr_sync2 uSuspSync (
      .clk    (clk),
      .resetn (resetn),
      .async  (suspendPin),
      .synced (suspSync)
   );

   // Software may also open access locally through the control register stop/suspend bits
   always_ff @(posedge clk) begin
      if (!resetn) begin
         stopSw_r <= 1'b0;
         suspSw_r <= 1'b0;
      end else if (ctlWr && avsByteenable[0]) begin
         stopSw_r <= avsWritedata[dsr_pkg::CTL_STOP_BIT];
         suspSw_r <= avsWritedata[dsr_pkg::CTL_SUSP_BIT];
      end
   end

   assign accessOpen = stopSync | suspSync | stopSw_r | suspSw_r;

   // One wait cycle per access: request seen, then ack cycle releases it
   assign req            = (avsRead | avsWrite) & ~ack_r;
   assign avsWaitrequest = (avsRead | avsWrite) & ~ack_r;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= req;
      end
   end

   // Writes land on the ack cycle, the edge where the master sees waitrequest low
   assign wrOk  = avsWrite & ack_r & accessOpen;
   assign ctlWr = avsWrite & ack_r & (avsAddress == dsr_pkg::IDX_CONTROL);
   assign stsWr = avsWrite & ack_r & (avsAddress == dsr_pkg::IDX_STATUS);
   // Byte lanes 0 and 1 only; upper lanes are reserved and ignored
   assign wrLow = {avsByteenable[1] ? avsWritedata[15:8] : 8'h00,
                   avsByteenable[0] ? avsWritedata[7:0]  : 8'h00};

   // Shadow write strobes; partial byte writes are treated as full low-half writes
   always_comb begin
      swCurRxCnt = 1'b0;
      swCurRxSt  = 1'b0;
      swCurTxCnt = 1'b0;
      swCurTxSt  = 1'b0;
      swNxtRxCnt = 1'b0;
      swNxtRxSt  = 1'b0;
      if (wrOk && avsAddress == dsr_pkg::IDX_CUR_RX_CNT) begin
         swCurRxCnt = 1'b1;
      end else if (wrOk && avsAddress == dsr_pkg::IDX_CUR_RX_STAT) begin
         swCurRxSt = 1'b1;
      end else if (wrOk && avsAddress == dsr_pkg::IDX_CUR_TX_CNT) begin
         swCurTxCnt = 1'b1;
      end else if (wrOk && avsAddress == dsr_pkg::IDX_CUR_TX_STAT) begin
         swCurTxSt = 1'b1;
      end else if (wrOk && avsAddress == dsr_pkg::IDX_NXT_RX_CNT) begin
         swNxtRxCnt = 1'b1;
      end else if (wrOk && avsAddress == dsr_pkg::IDX_NXT_RX_STAT) begin
         swNxtRxSt = 1'b1;
      end
   end

   // Shadow fields carry no reset so resets and stop leave them intact
   dsr_shadow_field #(.W(CW)) uCurRxCnt (
      .clk    (clk),
      .hwLoad (curRxLoad),
      .hwData (rx_descriptor_word1_cur[CW-1:0]),
      .swLoad (swCurRxCnt),
      .swData (wrLow[CW-1:0]),
      .value  (cur_rx_count_field)
   );
   dsr_shadow_field #(.W(SW)) uCurRxSt (
      .clk    (clk),
      .hwLoad (curRxLoad),
      .hwData (rx_descriptor_word1_cur[SL+SW-1:SL]),
      .swLoad (swCurRxSt),
      .swData (wrLow),
      .value  (cur_rx_status_field)
   );
   dsr_shadow_field #(.W(CW)) uCurTxCnt (
      .clk    (clk),
      .hwLoad (curTxLoad),
      .hwData (tx_descriptor_word1_cur[CW-1:0]),
      .swLoad (swCurTxCnt),
      .swData (wrLow[CW-1:0]),
      .value  (cur_tx_count_field)
   );
   dsr_shadow_field #(.W(SW)) uCurTxSt (
      .clk    (clk),
      .hwLoad (curTxLoad),
      .hwData (tx_descriptor_word1_cur[SL+SW-1:SL]),
      .swLoad (swCurTxSt),
      .swData (wrLow),
      .value  (cur_tx_status_field)
   );
   dsr_shadow_field #(.W(CW)) uNxtRxCnt (
      .clk    (clk),
      .hwLoad (nxtRxLoad),
      .hwData (rx_descriptor_word1_nxt[CW-1:0]),
      .swLoad (swNxtRxCnt),
      .swData (wrLow[CW-1:0]),
      .value  (nxt_rx_count_field)
   );
   dsr_shadow_field #(.W(SW)) uNxtRxSt (
      .clk    (clk),
      .hwLoad (nxtRxLoad),
      .hwData (rx_descriptor_word1_nxt[SL+SW-1:SL]),
      .swLoad (swNxtRxSt),
      .swData (wrLow),
      .value  (nxt_rx_status_field)
   );

   // Sticky flag: a shadow access arrived while access was closed
   // Set wins over a clear in the same cycle
   always_ff @(posedge clk) begin
      if (!resetn) begin
         refused_r <= 1'b0;
      end else if ((avsRead | avsWrite) && ack_r && !accessOpen
                   && avsAddress <= dsr_pkg::IDX_NXT_RX_STAT) begin
         refused_r <= 1'b1;
      end else if (stsWr && avsWritedata[dsr_pkg::STS_REFUSED_BIT]) begin
         refused_r <= 1'b0;
      end
   end

   // Read mux; closed access returns zero, reserved bits read zero
   always_comb begin
      rdNxt = dsr_pkg::ZERO_WORD;
      if (avsAddress == dsr_pkg::IDX_CONTROL) begin
         rdNxt[dsr_pkg::CTL_STOP_BIT] = stopSw_r;
         rdNxt[dsr_pkg::CTL_SUSP_BIT] = suspSw_r;
      end else if (avsAddress == dsr_pkg::IDX_STATUS) begin
         rdNxt[dsr_pkg::STS_REFUSED_BIT] = refused_r;
         rdNxt[1]                        = accessOpen;
      end else if (!accessOpen) begin
         rdNxt = dsr_pkg::ZERO_WORD;
      end else if (avsAddress == dsr_pkg::IDX_CUR_RX_CNT) begin
         rdNxt[CW-1:0] = cur_rx_count_field;
      end else if (avsAddress == dsr_pkg::IDX_CUR_RX_STAT) begin
         rdNxt[SW-1:0] = cur_rx_status_field;
      end else if (avsAddress == dsr_pkg::IDX_CUR_TX_CNT) begin
         rdNxt[CW-1:0] = cur_tx_count_field;
      end else if (avsAddress == dsr_pkg::IDX_CUR_TX_STAT) begin
         rdNxt[SW-1:0] = cur_tx_status_field;
      end else if (avsAddress == dsr_pkg::IDX_NXT_RX_CNT) begin
         rdNxt[CW-1:0] = nxt_rx_count_field;
      end else if (avsAddress == dsr_pkg::IDX_NXT_RX_STAT) begin
         rdNxt[SW-1:0] = nxt_rx_status_field;
      end else begin
         rdNxt = dsr_pkg::UNMAPPED_VALUE;
      end
   end

   // Read data registered on the request cycle so it stands at the ack edge
   always_ff @(posedge clk) begin
      if (!resetn) begin
         avsReaddata <= dsr_pkg::ZERO_WORD;
      end else if (avsRead && !ack_r) begin
         avsReaddata <= rdNxt;
      end
   end
endmodule
`default_nettype wire

// >>> verification/dsr_props.sv
// Purpose: Port checks for the descriptor shadow register bank
// Assumes: One clock, synchronous active-low reset
// Notes:   Reset hold is checked only once every shadow holds real data
`timescale 1ns/1ps
`default_nettype none
module dsr_props (
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic [3:0]  avsAddress,
   input wire logic        avsRead,
   input wire logic        avsWrite,
   input wire logic [31:0] avsReaddata,
   input wire logic        avsWaitrequest,
   input wire logic        curRxLoad,
   input wire logic [31:0] rx_descriptor_word1_cur,
   input wire logic        curTxLoad,
   input wire logic [31:0] tx_descriptor_word1_cur,
   input wire logic        nxtRxLoad,
   input wire logic [31:0] rx_descriptor_word1_nxt,
   input wire logic [11:0] cur_rx_count_field,
   input wire logic [15:0] cur_rx_status_field,
   input wire logic [11:0] cur_tx_count_field,
   input wire logic [15:0] cur_tx_status_field,
   input wire logic [11:0] nxt_rx_count_field,
   input wire logic [15:0] nxt_rx_status_field,
   input wire logic        accessOpen
);
   wire logic [83:0] allF = {cur_rx_count_field, cur_rx_status_field, cur_tx_count_field,
                             cur_tx_status_field, nxt_rx_count_field, nxt_rx_status_field};
   wire logic        anyLd = curRxLoad | curTxLoad | nxtRxLoad;
   logic [2:0]       seenLd_r = 3'b000;
   // Unloaded shadows are unknown, so the reset hold check waits for all three loads
   always_ff @(posedge clk) seenLd_r <= seenLd_r | {nxtRxLoad, curTxLoad, curRxLoad};
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   a_rx_cnt_copy:
      assert property (curRxLoad |=> {20'h0_0000, cur_rx_count_field} ==
         ($past(rx_descriptor_word1_cur) & 32'h0000_0FFF)) else $error("rx count copy");
   a_rx_stat_copy:
      assert property (curRxLoad |=> {cur_rx_status_field, 16'h0000} ==
         ($past(rx_descriptor_word1_cur) & 32'hFFFF_0000)) else $error("rx status copy");
   a_tx_cnt_copy:
      assert property (curTxLoad |=> {20'h0_0000, cur_tx_count_field} ==
         ($past(tx_descriptor_word1_cur) & 32'h0000_0FFF)) else $error("tx count copy");
   a_tx_stat_copy:
      assert property (curTxLoad |=> {cur_tx_status_field, 16'h0000} ==
         ($past(tx_descriptor_word1_cur) & 32'hFFFF_0000)) else $error("tx status copy");
   a_nxt_cnt_copy:
      assert property (nxtRxLoad |=> {20'h0_0000, nxt_rx_count_field} ==
         ($past(rx_descriptor_word1_nxt) & 32'h0000_0FFF)) else $error("next count copy");
   a_nxt_stat_copy:
      assert property (nxtRxLoad |=> {nxt_rx_status_field, 16'h0000} ==
         ($past(rx_descriptor_word1_nxt) & 32'hFFFF_0000)) else $error("next status copy");
   a_closed_write:
      assert property (avsWrite && !avsWaitrequest && !accessOpen && !anyLd |=> $stable(allF))
         else $error("closed write landed");
   a_closed_read:
      assert property (avsRead && !avsWaitrequest && !accessOpen && avsAddress < 4'h6 |->
         avsReaddata == 32'h0000_0000) else $error("closed read leaked");
   a_one_wait:
      assert property ((avsRead || avsWrite) && avsWaitrequest |=> !avsWaitrequest)
         else $error("wait state too long");
   a_reset_keeps:
      assert property (disable iff (1'b0) !resetn && &seenLd_r && !anyLd |=> $stable(allF))
         else $error("reset changed shadow");
   a_count_upper:
      assert property (avsRead && !avsWaitrequest && !avsAddress[0] && avsAddress < 4'h6 |->
         avsReaddata[31:12] == 20'h0_0000) else $error("count upper bits set");
endmodule
bind dsr_descriptor_shadow_registers dsr_props CHK (.*);
`default_nettype wire

// >>> verification/dsr_engine_model.sv
// Purpose: Descriptor engine stand-in that pulses shadow loads
// Assumes: Same clock as the register bank
// Notes:   Word lines invert outside the load cycle to expose late sampling
`timescale 1ns/1ps
`default_nettype none
module dsr_engine_model (
   input  wire logic        clk,
   input  wire logic        fire,
   input  wire logic [1:0]  sel,
   input  wire logic [31:0] word,
   output var  logic        curRxLoad = 1'b0,
   output var  logic        curTxLoad = 1'b0,
   output var  logic        nxtRxLoad = 1'b0,
   output var  logic [31:0] rx_descriptor_word1_cur = 32'h0000_0000,
   output var  logic [31:0] tx_descriptor_word1_cur = 32'h0000_0000,
   output var  logic [31:0] rx_descriptor_word1_nxt = 32'h0000_0000
);
   // One-cycle load pulse for the chosen descriptor
   always_ff @(posedge clk) begin
      curRxLoad <= fire && sel == 2'h0;
      curTxLoad <= fire && sel == 2'h1;
      nxtRxLoad <= fire && sel == 2'h2;
   end
   // Word valid only beside its pulse
   always_ff @(posedge clk) begin
      rx_descriptor_word1_cur <= (fire && sel == 2'h0) ? word : ~rx_descriptor_word1_cur;
      tx_descriptor_word1_cur <= (fire && sel == 2'h1) ? word : ~tx_descriptor_word1_cur;
      rx_descriptor_word1_nxt <= (fire && sel == 2'h2) ? word : ~rx_descriptor_word1_nxt;
   end
endmodule
`default_nettype wire

// >>> verification/tb_descriptor_shadow_registers.sv
// Purpose: Self-checking bench for the descriptor shadow register bank
// Assumes: Avalon accesses with waitrequest, engine model on the same clock
// Notes:   Byte enables tied high; only lanes 0 and 1 matter
`timescale 1ns/1ps
`default_nettype none
module tb_descriptor_shadow_registers;
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic [3:0]  avsAddress = 4'h0;
   logic        avsRead = 1'b0;
   logic        avsWrite = 1'b0;
   logic [31:0] avsWritedata = 32'h0000_0000;
   logic [3:0]  avsByteenable = 4'hF;
   logic        stopPin = 1'b0;
   logic        suspendPin = 1'b0;
   logic        fire = 1'b0;
   logic [1:0]  sel = 2'h0;
   logic [31:0] word = 32'h0000_0000;
   logic [31:0] avsReaddata, rx_descriptor_word1_cur;
   logic [31:0] tx_descriptor_word1_cur, rx_descriptor_word1_nxt;
   logic        avsWaitrequest, curRxLoad, curTxLoad, nxtRxLoad, accessOpen;
   logic [11:0] cur_rx_count_field, cur_tx_count_field, nxt_rx_count_field;
   logic [15:0] cur_rx_status_field, cur_tx_status_field, nxt_rx_status_field;
   logic [31:0] w [3] = '{32'hABCD_F123, 32'h5A5A_7E9C, 32'h1357_8642};
   int          err_total = 0;
   int          checked = 0;
   dsr_descriptor_shadow_registers DUT (.*);
   dsr_engine_model ENG (.*);
   // Free-running 40 MHz clock
   always #12.5 clk = ~clk;
   // Expected register image: count in 11-0, status in 15-0, rest zero
   function automatic logic [31:0] ex(input int k);
      return (k % 2) ? {16'h0000, w[k/2][31:16]} : {20'h0_0000, w[k/2][11:0]};
   endfunction
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         err_total++;
         $display("[FAIL] %0t read %h expected %h", $time, s, e);
      end
   endtask
   // Holds the request until waitrequest is seen low at a rising edge
   task automatic acc(input logic wr, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      avsAddress <= a;
      avsWrite <= wr;
      avsRead <= !wr;
      avsWritedata <= d;
      // Waitrequest is looked at only on rising edges; the low edge is the transfer edge
      do begin
         @(posedge clk);
         n++;
      end while (avsWaitrequest !== 1'b0 && n < 20);
      q = avsReaddata;
      avsRead <= 1'b0;
      avsWrite <= 1'b0;
      if (n >= 20) err_total++;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] q;
      acc(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      logic [31:0] q;
      acc(1'b0, a, 32'h0000_0000, q);
      chk(q, e);
   endtask
   task automatic eng(input logic [1:0] s, input logic [31:0] v);
      @(posedge clk);
      fire <= 1'b1;
      sel <= s;
      word <= v;
      @(posedge clk);
      fire <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   task automatic finish_test;
      if (err_total == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Main sequence: closed, stopped, suspended, closed again, reset mid-run
   initial begin
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      for (int k = 0; k < 3; k++) eng(2'(k), w[k]);
      for (int k = 0; k < 6; k++) rd(4'(k), 32'h0000_0000);
      rd(4'h7, 32'h0000_0001);
      wr(4'h7, 32'h0000_0001);
      wr(4'h6, 32'h0000_0001);
      rd(4'h7, 32'h0000_0002);
      for (int k = 0; k < 6; k++) rd(4'(k), ex(k));
      wr(4'h0, 32'hFFFF_FFFF);
      rd(4'h0, 32'h0000_0FFF);
      wr(4'h1, 32'hFFFF_FFFF);
      rd(4'h1, 32'h0000_FFFF);
      eng(2'h0, w[0]);
      suspendPin <= 1'b1;
      wr(4'h6, 32'h0000_0000);
      wr(4'h2, 32'h0000_0ABC);
      w[1][11:0] = 12'hABC;
      rd(4'h2, ex(2));
      suspendPin <= 1'b0;
      repeat (3) @(posedge clk);
      wr(4'h2, 32'h0000_0555);
      rd(4'h7, 32'h0000_0001);
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      rd(4'h6, 32'h0000_0000);
      wr(4'h6, 32'h0000_0001);
      for (int k = 0; k < 6; k++) rd(4'(k), ex(k));
      rd(4'h9, 32'h0000_0000);
      finish_test;
   end
   // Watchdog well beyond the expected run length
   initial begin
      repeat (3000) @(posedge clk);
      err_total++;
      finish_test;
   end
endmodule
`default_nettype wire
